// file: pagpio_consts.svh
// register offsets, reset values and field positions of the port a low-pin block
`ifndef PAGPIO_CONSTS_SVH
`define PAGPIO_CONSTS_SVH

`define PAGPIO_ADDR_W 3
`define PAGPIO_DATA_W 8
`define PAGPIO_PINS 6

`define PAGPIO_OFS_DATA 3'h0
`define PAGPIO_OFS_DIR 3'h1
`define PAGPIO_OFS_PULL 3'h2
`define PAGPIO_OFS_DIER 3'h3
`define PAGPIO_OFS_PIN 3'h4
`define PAGPIO_OFS_ALTFN 3'h5
`define PAGPIO_OFS_STAT 3'h6
`define PAGPIO_OFS_MASK 3'h7

`define PAGPIO_RST_DATA 6'h00
`define PAGPIO_RST_DIR 6'h00
`define PAGPIO_RST_PULL 5'h00
`define PAGPIO_RST_DIER 6'h3f
`define PAGPIO_RST_ALTFN 6'h00
`define PAGPIO_RST_MASK 2'h0

`define PAGPIO_ALT_PWM2 0
`define PAGPIO_ALT_PWM3 1
`define PAGPIO_ALT_PWM4 2
`define PAGPIO_ALT_HALL5 3
`define PAGPIO_ALT_RST5 4
`define PAGPIO_ALT_CAP5 5

`define PAGPIO_ST_EXT0 0
`define PAGPIO_ST_WAKE 1

`endif

// file: pagpio_pkg.sv
// types shared by the port a low-pin block
`include "pagpio_consts.svh"

package pagpio_pkg;

    typedef struct packed {
        logic [`PAGPIO_ADDR_W-1:0] addr;
        logic [`PAGPIO_DATA_W-1:0] wdata;
        logic we;
        logic re;
    } pagpio_bus_t;

    typedef struct packed {
        logic [`PAGPIO_PINS-1:0] out;
        logic [`PAGPIO_PINS-1:0] oe;
        logic [`PAGPIO_PINS-1:0] pu;
    } pagpio_pad_t;

endpackage

// file: pagpio_top.sv
// pad-side logic for port a bits 0 to 5: direction, pull-ups, alternates, wake and edge irq
`timescale 1ns/10ps
`default_nettype none
`include "pagpio_consts.svh"

module pagpio_top
    import pagpio_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register port
    input wire pagpio_bus_t bus_req,
    output logic [`PAGPIO_DATA_W-1:0] rdata,
    // pads
    input wire logic [`PAGPIO_PINS-1:0] pad_in,
    output pagpio_pad_t pad,
    // alternate sources and system state
    input wire logic pwm_in,
    input wire logic hall_comparator_out,
    input wire logic sleep_mode,
    // events and alternate sinks
    output logic external_irq_line0,
    output logic wake_req,
    output logic pulse_capture_in,
    output logic hw_reset_n,
    output logic irq
);

    // =========================================================
    // register file
    logic [5:0] data_q;
    logic [5:0] dir_q;
    logic [4:0] pull_q;
    logic [5:0] dier_q;
    logic [5:0] altfn_q;
    logic [1:0] mask_q;
    logic [1:0] status_q;
    logic [1:0] status_d;
    logic [`PAGPIO_DATA_W-1:0] rdata_q;
    logic wr_hit;

    assign wr_hit = bus_req.we;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            data_q <= `PAGPIO_RST_DATA;
            dir_q <= `PAGPIO_RST_DIR;
            pull_q <= `PAGPIO_RST_PULL;
            dier_q <= `PAGPIO_RST_DIER;
            altfn_q <= `PAGPIO_RST_ALTFN;
            mask_q <= `PAGPIO_RST_MASK;
        end else if (wr_hit) begin
            case (bus_req.addr)
                `PAGPIO_OFS_DATA: data_q <= bus_req.wdata[5:0];
                `PAGPIO_OFS_DIR: dir_q <= bus_req.wdata[5:0];
                `PAGPIO_OFS_PULL: pull_q <= bus_req.wdata[4:0];
                `PAGPIO_OFS_DIER: dier_q <= bus_req.wdata[5:0];
                `PAGPIO_OFS_ALTFN: altfn_q <= bus_req.wdata[5:0];
                `PAGPIO_OFS_MASK: mask_q <= bus_req.wdata[1:0];
                default: ;
            endcase
        end
    end

    // =========================================================
    // pin synchroniser, stage one feeds stage two only
    logic [5:0] pin_s1_q;
    logic [5:0] pin_s2_q;
    logic [5:0] pin_s3_q;
    logic [5:0] pin_gated;
    logic [5:0] pin_chg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
            pin_s3_q <= 6'h00;
        end else begin
            pin_s1_q <= pad_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // a disabled input buffer reads as zero and can neither wake nor interrupt
    assign pin_gated = pin_s2_q & dier_q;
    assign pin_chg = (pin_s2_q ^ pin_s3_q) & dier_q;

    // =========================================================
    // events
    logic ext0_ev;
    logic wake_ev;
    logic ext_irq_q;
    logic wake_q;

    assign ext0_ev = pin_chg[0];
    assign wake_ev = sleep_mode & (|pin_chg);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ext_irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            ext_irq_q <= ext0_ev;
            wake_q <= wake_ev;
        end
    end

    // =========================================================
    // sticky status, cleared by read; a new event in the read cycle survives
    logic stat_rd;
    logic irq_q;

    assign stat_rd = bus_req.re && (bus_req.addr == `PAGPIO_OFS_STAT);

    always_comb begin
        status_d = stat_rd ? 2'h0 : status_q;
        if (ext0_ev) begin
            status_d[`PAGPIO_ST_EXT0] = 1'b1;
        end
        if (wake_ev) begin
            status_d[`PAGPIO_ST_WAKE] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
        end
    end

    // =========================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (bus_req.re) begin
            case (bus_req.addr)
                `PAGPIO_OFS_DATA: rdata_q <= {2'h0, data_q};
                `PAGPIO_OFS_DIR: rdata_q <= {2'h0, dir_q};
                `PAGPIO_OFS_PULL: rdata_q <= {3'h0, pull_q};
                `PAGPIO_OFS_DIER: rdata_q <= {2'h0, dier_q};
                `PAGPIO_OFS_PIN: rdata_q <= {2'h0, pin_gated};
                `PAGPIO_OFS_ALTFN: rdata_q <= {2'h0, altfn_q};
                `PAGPIO_OFS_STAT: rdata_q <= {6'h00, status_q};
                `PAGPIO_OFS_MASK: rdata_q <= {6'h00, mask_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // =========================================================
    // pad drive
    pagpio_pad_t pad_d;
    pagpio_pad_t pad_q;
    logic [2:0] pwm_sel;
    logic hall_sel;
    logic rst_sel;
    logic cap_q;
    logic hw_rst_n_q;

    assign pwm_sel = altfn_q[`PAGPIO_ALT_PWM4:`PAGPIO_ALT_PWM2];
    assign rst_sel = altfn_q[`PAGPIO_ALT_RST5];
    assign hall_sel = altfn_q[`PAGPIO_ALT_HALL5] & ~rst_sel;

    always_comb begin
        // push-pull low bits, pull-up only while the pin is an input
        pad_d.out[4:0] = data_q[4:0];
        pad_d.oe[4:0] = dir_q[4:0];
        pad_d.pu[4:0] = pull_q & ~dir_q[4:0];
        for (int i = 0; i < 3; i++) begin
            if (pwm_sel[i]) begin
                pad_d.out[i+2] = pwm_in;
                pad_d.oe[i+2] = 1'b1;
                pad_d.pu[i+2] = 1'b0;
            end
        end
        // bit 5 only ever sinks; reset mode keeps it a pure input
        pad_d.out[5] = 1'b0;
        pad_d.pu[5] = 1'b0;
        if (rst_sel) begin
            pad_d.oe[5] = 1'b0;
        end else if (hall_sel) begin
            pad_d.oe[5] = ~hall_comparator_out;
        end else begin
            pad_d.oe[5] = dir_q[5] & ~data_q[5];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pad_q <= '0;
            cap_q <= 1'b0;
            hw_rst_n_q <= 1'b1;
        end else begin
            pad_q <= pad_d;
            cap_q <= altfn_q[`PAGPIO_ALT_CAP5] ? pin_gated[5] : pin_gated[0];
            hw_rst_n_q <= rst_sel ? pin_s2_q[5] : 1'b1;
        end
    end

    assign pad = pad_q;
    assign rdata = rdata_q;
    assign external_irq_line0 = ext_irq_q;
    assign wake_req = wake_q;
    assign pulse_capture_in = cap_q;
    assign hw_reset_n = hw_rst_n_q;
    assign irq = irq_q;

    // =========================================================
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_bit0_edge;
        dier_q[0] && (pin_s2_q[0] != pin_s3_q[0]);
    endsequence

    sequence s_wake_edge;
        sleep_mode && ((pin_s2_q ^ pin_s3_q) & dier_q) != 6'h00;
    endsequence

    a_bit5_no_pull: assert property (!pad.pu[5] && !pad.out[5])
        else $error("bit 5 drove high or pulled up");

    a_low_pull_input: assert property (dir_q[4:0] == 5'h1f |-> ##1 pad.pu[4:0] == 5'h00)
        else $error("pull-up active on an output");

    a_low_dir_follow: assert property (pwm_sel == 3'h0 |=> pad.oe[4:0] == $past(dir_q[4:0]))
        else $error("output enable not following direction");

    a_wake_gate: assert property (!sleep_mode || dier_q == 6'h00 |=> !wake_req)
        else $error("wake with gating active");

    a_wake_fire: assert property (s_wake_edge |=> wake_req)
        else $error("enabled pin change did not wake");

    a_ext0_both: assert property (s_bit0_edge |=> external_irq_line0 ##0 status_q[0])
        else $error("bit 0 edge missed");

    a_ext0_gated: assert property (!dier_q[0] |=> !external_irq_line0)
        else $error("irq from disabled bit 0");

    a_pwm_route: assert property (pwm_sel[0] |=> pad.out[2] == $past(pwm_in) && pad.oe[2])
        else $error("pwm not on bit 2");

    a_cap_route: assert property (!altfn_q[`PAGPIO_ALT_CAP5] |=> pulse_capture_in == $past(pin_gated[0]))
        else $error("capture not from bit 0");

    a_rst_pass: assert property (rst_sel |=> hw_reset_n == $past(pin_s2_q[5]) && !pad.oe[5])
        else $error("reset function not on bit 5");

    a_sync_delay: assert property ($changed(pad_in[0]) ##1 $stable(pad_in[0]) ##1 $stable(pad_in[0])
        |-> pin_s2_q[0] == pad_in[0])
        else $error("synchroniser depth wrong");

    // =========================================================
    // register port, status and remaining routes
    // a read that meets a fresh event must not lose it, so the clear check excludes that cycle
    sequence s_stat_read;
        bus_req.re && bus_req.addr == `PAGPIO_OFS_STAT;
    endsequence

    sequence s_no_read;
        !bus_req.re;
    endsequence

    sequence s_bit5_change;
        dier_q[5] && (pin_s2_q[5] != pin_s3_q[5]);
    endsequence

    a_rdata_idle: assert property (s_no_read |=> rdata == 8'h00)
        else $error("read data not zero outside a read");

    a_stat_clear: assert property (s_stat_read ##0 (!ext0_ev && !wake_ev) |=> status_q == 2'h0)
        else $error("status not cleared by read");

    a_stat_sticky: assert property (!stat_rd && status_q[0] |=> status_q[0])
        else $error("status bit lost without read");

    a_irq_level: assert property (1'b1 |=> irq == |(status_q & $past(mask_q)))
        else $error("irq level does not match status and mask");

    a_ext0_irq: assert property (ext0_ev && mask_q[0] |=> irq)
        else $error("unmasked bit 0 edge gave no irq");

    a_ext0_pulse: assert property (external_irq_line0 |-> $past(pin_s2_q[0]) != $past(pin_s3_q[0]))
        else $error("irq pulse without a synchronised edge");

    a_bit5_wake: assert property (s_bit5_change ##0 sleep_mode |=> wake_req)
        else $error("bit 5 change did not wake");

    a_bit5_no_wake: assert property (!dier_q[5] && sleep_mode && pin_chg[4:0] == 5'h00 |=> !wake_req)
        else $error("wake from a gated bit 5");

    a_wake_status: assert property (wake_ev |=> status_q[`PAGPIO_ST_WAKE])
        else $error("wake event not recorded");

    a_pad_low_out: assert property (pwm_sel == 3'h0 |=> pad.out[4:0] == $past(data_q[4:0]))
        else $error("output data not on low pads");

    a_pull_input: assert property (pwm_sel == 3'h0 |=> pad.pu[4:0] == ($past(pull_q) & ~$past(dir_q[4:0])))
        else $error("pull-up selection wrong");

    a_pwm_bit3: assert property (pwm_sel[1] |=> pad.out[3] == $past(pwm_in) && pad.oe[3] && !pad.pu[3])
        else $error("pwm not on bit 3");

    a_pwm_bit4: assert property (pwm_sel[2] |=> pad.out[4] == $past(pwm_in) && pad.oe[4] && !pad.pu[4])
        else $error("pwm not on bit 4");

    a_hall_route: assert property (hall_sel |=> pad.oe[5] == !$past(hall_comparator_out))
        else $error("hall output not on bit 5");

    a_bit5_open_drain: assert property (!rst_sel && !hall_sel
        |=> pad.oe[5] == ($past(dir_q[5]) && !$past(data_q[5])))
        else $error("bit 5 open-drain drive wrong");

    a_cap_bit5: assert property (altfn_q[`PAGPIO_ALT_CAP5] |=> pulse_capture_in == $past(pin_gated[5]))
        else $error("capture not from bit 5");

    a_rst_idle: assert property (!rst_sel |=> hw_reset_n)
        else $error("reset asserted while function off");

endmodule

`default_nettype wire

// file: pagpio_board.sv
// board-side model of the six port a pads
`timescale 1ns/10ps
`default_nettype none

module pagpio_board
    import pagpio_pkg::*;
(
    // drive from the block and from the board
    input wire pagpio_pad_t pad,
    input wire logic [5:0] ext_en,
    input wire logic [5:0] ext_val,
    // resolved pad levels
    output logic [5:0] lvl
);
    logic [5:0] last = 6'h00;

    // a released line without pull-up must not keep showing its old level
    always @* begin
        for (int i = 0; i < 6; i++) begin
            if (ext_en[i] || pad.oe[i] || pad.pu[i]) begin
                lvl[i] = ext_en[i] ? ext_val[i] : (pad.oe[i] ? pad.out[i] : 1'b1);
                last[i] = lvl[i];
            end else begin
                lvl[i] = ~last[i];
            end
        end
    end
endmodule

`default_nettype wire

// file: tb_port_a_low_pin_logic.sv
// self-checking bench for the port a low-pin block
`timescale 1ns/10ps
`default_nettype none
`include "pagpio_consts.svh"

module tb_port_a_low_pin_logic
    import pagpio_pkg::*;
;
    logic clk_sys, srst, pwm_in, hall, sleep_mode, ext_irq, wake_req, cap, hw_reset_n, irq;
    pagpio_bus_t bus_req;
    pagpio_pad_t pad;
    logic [7:0] rdata, v;
    logic [5:0] pad_in, ext_en, ext_val, r, d;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00};
    int failures = 0;
    int samples_checked = 0;
    int ni, nw, b, den, slp;

    pagpio_top i_pagpio_top (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
        .rdata(rdata), .pad_in(pad_in), .pad(pad), .pwm_in(pwm_in),
        .hall_comparator_out(hall), .sleep_mode(sleep_mode),
        .external_irq_line0(ext_irq), .wake_req(wake_req), .pulse_capture_in(cap),
        .hw_reset_n(hw_reset_n), .irq(irq));
    pagpio_board i_pagpio_board (.pad(pad), .ext_en(ext_en), .ext_val(ext_val), .lvl(pad_in));

    // =====================================
    // helpers
    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: x, we: 1'b1, re: 1'b0};
        @(posedge clk_sys);
        bus_req.we <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.re <= 1'b1;
        @(posedge clk_sys);
        bus_req.re <= 1'b0;
        #1 x = rdata;
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] t;
        rd(a, t);
        chk(t, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // pulses are counted away from the edge that launches them
    always @(negedge clk_sys) begin
        if (ext_irq === 1'b1) ni++;
        if (wake_req === 1'b1) nw++;
    end

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #(40 * 5000);
        failures++;
        conclude();
    end

    // =====================================
    // stimulus
    initial begin
        srst = 1'b1;
        bus_req = '0;
        pwm_in = 1'b0;
        hall = 1'b0;
        sleep_mode = 1'b0;
        ext_en = 6'h3f;
        ext_val = 6'h00;
        void'($urandom(28));
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        wr(`PAGPIO_OFS_PIN, 8'hff);
        wr(`PAGPIO_OFS_STAT, 8'hff);
        for (int a = 0; a < 8; a++) rc(3'(a), rst_tab[a]);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            d = 6'($urandom);
            r = 6'($urandom);
            v = 8'($urandom);
            wr(`PAGPIO_OFS_DATA, {2'h0, d});
            wr(`PAGPIO_OFS_DIR, {2'h0, r});
            wr(`PAGPIO_OFS_PULL, v);
            settle(2);
            chk({2'h0, pad.oe}, {2'h0, r[5] & ~d[5], r[4:0]});
            chk({2'h0, pad.out & pad.oe}, {3'h0, d[4:0] & r[4:0]});
            chk({2'h0, pad.pu}, {3'h0, v[4:0] & ~r[4:0]});
        end
        $display("test pad drive done");
        wr(`PAGPIO_OFS_DIR, 8'h00);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            pwm_in <= k[0];
            hall <= k[1];
            ext_val <= 6'($urandom);
            wr(`PAGPIO_OFS_ALTFN, 8'h0f);
            settle(2);
            chk({5'h0, pad.oe[4:2]}, 8'h07);
            chk({5'h0, pad.out[4:2]}, {5'h0, {3{k[0]}}});
            chk({7'h0, pad.oe[5]}, {7'h0, ~k[1]});
            wr(`PAGPIO_OFS_ALTFN, 8'h30);
            settle(3);
            chk({6'h0, hw_reset_n, cap}, {6'h0, ext_val[5], ext_val[5]});
            wr(`PAGPIO_OFS_ALTFN, 8'h00);
            settle(3);
            chk({6'h0, hw_reset_n, cap}, {6'h0, 1'b1, ext_val[0]});
        end
        $display("test alternates done");
        @(posedge clk_sys);
        ext_val <= 6'h00;
        wr(`PAGPIO_OFS_MASK, 8'h03);
        for (int i = 0; i < 18; i++) begin
            b = i % 6;
            den = i < 12;
            slp = (i / 6) != 1;
            if (b == 0) begin
                wr(`PAGPIO_OFS_DIER, den ? 8'h3f : 8'h00);
                settle(4);
            end
            rd(`PAGPIO_OFS_STAT, v);
            @(posedge clk_sys);
            sleep_mode <= 1'(slp);
            ext_val[b] <= ~ext_val[b];
            ni = 0;
            nw = 0;
            settle(6);
            chk(8'(ni * 16 + nw), {3'h0, den && b == 0, 3'h0, den && slp});
            chk({7'h0, irq}, {7'h0, den && (slp || b == 0)});
            rc(`PAGPIO_OFS_PIN, {2'h0, ext_val & (den ? 6'h3f : 6'h00)});
            rc(`PAGPIO_OFS_STAT, {6'h0, den && slp, den && b == 0});
        end
        $display("test events done");
        conclude();
    end
endmodule

`default_nettype wire
